// ===== logic/lrpm_pkg.sv
// Shared constants for the display reset and power-mode sequencer.
// Assumes a 40 MHz APB clock; all counts are in pclk cycles.
package lrpm_pkg;

    localparam int CLK_MHZ = 40;
    localparam int POR_TIME_US = 5000;
    localparam int POR_CYCLES_DEF = POR_TIME_US * CLK_MHZ;
    localparam int RESET_SEQ_CYCLES_DEF = 64;
    localparam int OSC_DIV_DEF = 40;

    // APB byte offsets
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_DATA = 8'h04;
    localparam logic [7:0] OFS_CFG = 8'h08;
    localparam logic [7:0] OFS_SCAN = 8'h0C;

    // Host commands
    localparam logic [7:0] CMD_SYS_RESET = 8'hE2;
    localparam logic [7:0] CMD_DISP_MASK = 8'hFE;
    localparam logic [7:0] CMD_DISP_VAL = 8'hAE;
    localparam logic [7:0] CMD_MAP_MASK = 8'hF8;
    localparam logic [7:0] CMD_MAP_VAL = 8'hC0;
    localparam int MAP_ROW_MIRROR_BIT = 2;
    localparam int MAP_COL_MIRROR_BIT = 1;

    // Status byte positions
    localparam int ST_MODE_LSB = 0;
    localparam int ST_DRV_EN_BIT = 2;
    localparam int ST_DRIVING_BIT = 3;
    localparam int ST_RIP_BIT = 4;
    localparam int ST_BUSY_BIT = 5;

    // Configuration register fields and defaults
    localparam int CFG_SL_LSB = 0;
    localparam int CFG_LAST_ROW_LSB = 8;
    localparam logic [6:0] SL_RESET = 7'h00;
    localparam logic [6:0] LAST_ROW_RESET = 7'h7F;

    typedef enum logic [1:0] {
        LRPM_MODE_RESET = 2'b00,
        LRPM_MODE_SLEEP = 2'b10,
        LRPM_MODE_NORMAL = 2'b11
    } lrpm_mode_t;

    typedef enum logic [1:0] {
        LRPM_SEQ_POR = 2'b00,
        LRPM_SEQ_RESET = 2'b01,
        LRPM_SEQ_RUN = 2'b10
    } lrpm_seq_t;

endpackage

// ===== logic/lrpm_ctrl.sv
// Reset and power-mode sequencer of a passive matrix display controller, APB slave.
// Assumes pins arrive asynchronously and an APB master on pclk.
//
// Function
// - After power-up wait about 5 ms, then start system reset automatically.
// - Software reset command or low reset pin also starts system reset.
// - Reset-in-progress and busy flags stay one until reset finishes.
// - During reset only the status read is served; other commands dropped.
// - Reset restores control registers to defaults and mode to reset.
// - Mode field: 00 reset, 10 sleep, 11 normal; clock, drivers, pump only normal.
// - Entering reset or sleep disables row and column drivers at once.
// - Draining path on in reset and sleep, off in normal.
// - Changing driver enable updates the mode field automatically.
// - Driver enable zero gives sleep, one gives normal.
// - Mode changes are applied on internal clock edges only; entry to reset mode does not wait for an oscillator tick.
// - Sleep keeps control registers; reset restores defaults.
// - Drivers stay idle until drive and bias voltages report ready.
// - Commands may follow back to back with no extra delay.
// - External panel drive voltage is never drained during reset.
// - Each cycle carries command/data select and write/read select.
// - Display on/off command bit 0 is driver enable; memory kept while asleep.
// - Display byte holds four 2-bit pixels, bits 1:0 lowest line.
// - Without row mirror, frame starts at start line, then line plus one mod 128.
// - With row mirror, frame starts at start line plus rows minus one, then minus one.
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/100ps
module lrpm_ctrl
    import lrpm_pkg::*;
#(
    parameter int POR_CYCLES = POR_CYCLES_DEF,
    parameter int RESET_SEQ_CYCLES = RESET_SEQ_CYCLES_DEF,
    parameter int OSC_DIV = OSC_DIV_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic reset_pin_n,
    input wire logic vlcd_ready,
    input wire logic vbias_ready,
    input wire logic vlcd_external,
    output logic reset_in_progress_flag,
    output logic busy_flag,
    output logic [1:0] operating_mode_field,
    output logic osc_en,
    output logic pump_en,
    output logic row_drv_en,
    output logic col_drv_en,
    output logic drain_vlcd_en,
    output logic drain_bias_en,
    output logic frame_start,
    output logic [6:0] scan_line,
    output logic [1:0] scan_pixel
);

    generate
        if (POR_CYCLES < 2 || RESET_SEQ_CYCLES < 1 || OSC_DIV < 2 || OSC_DIV > 400) begin : g_bad
            $error("lrpm_ctrl: unsupported parameter values");
        end
    endgenerate

    localparam int PCW = $clog2(POR_CYCLES + 1);
    localparam int RCW = $clog2(RESET_SEQ_CYCLES + 1);
    localparam int OCW = $clog2(OSC_DIV + 1);

    function automatic logic [1:0] pixel_of(input logic [7:0] b, input logic [1:0] sel);
        pixel_of = b[{sel, 1'b0} +: 2];
    endfunction

    // Pin synchronisers
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta <= 4'hF;
            pin_sync <= 4'hF;
        end else begin
            pin_meta <= {reset_pin_n, vlcd_ready, vbias_ready, vlcd_external};
            pin_sync <= pin_meta;
        end
    end
    wire pin_rst_low = !pin_sync[3];
    wire volts_ready = pin_sync[2] && pin_sync[1];
    wire ext_vlcd = pin_sync[0];

    // APB decode
    wire setup = psel && !penable;
    wire access = psel && penable && pready;
    wire wr_access = access && pwrite;
    wire hit_cmd = paddr == OFS_CMD;
    wire hit_data = paddr == OFS_DATA;
    wire hit_cfg = paddr == OFS_CFG;
    wire hit_scan = paddr == OFS_SCAN;
    wire mapped = hit_cmd || hit_data || hit_cfg || hit_scan;

    lrpm_seq_t seq;
    logic [PCW-1:0] por_cnt;
    logic [RCW-1:0] rst_cnt;
    lrpm_mode_t mode;
    logic driver_enable_bit;
    logic mode_pending;
    logic row_mirror;
    logic column_mirror;
    logic [6:0] start_line_offset;
    logic [6:0] last_scanned_row;
    logic [7:0] display_byte;
    logic [OCW-1:0] osc_cnt;
    logic osc_tick;
    logic [6:0] row_cnt;

    wire rip = seq != LRPM_SEQ_RUN;
    wire cmd_ok = wr_access && pstrb[0] && !rip;
    wire cmd_wr = cmd_ok && hit_cmd;
    wire [7:0] cmd = pwdata[7:0];
    wire sw_reset = cmd_wr && cmd == CMD_SYS_RESET;
    wire disp_cmd = cmd_wr && (cmd & CMD_DISP_MASK) == CMD_DISP_VAL;
    wire map_cmd = cmd_wr && (cmd & CMD_MAP_MASK) == CMD_MAP_VAL;
    wire start_reset = sw_reset || pin_rst_low;

    // Reset sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq <= LRPM_SEQ_POR;
            por_cnt <= '0;
            rst_cnt <= '0;
        end else begin
            case (seq)
                LRPM_SEQ_POR: begin
                    if (por_cnt == PCW'(POR_CYCLES - 1)) begin
                        seq <= LRPM_SEQ_RESET;
                        rst_cnt <= '0;
                    end else begin
                        por_cnt <= por_cnt + 1'b1;
                    end
                end
                LRPM_SEQ_RESET: begin
                    if (pin_rst_low) begin
                        rst_cnt <= '0;
                    end else if (rst_cnt == RCW'(RESET_SEQ_CYCLES - 1)) begin
                        seq <= LRPM_SEQ_RUN;
                    end else begin
                        rst_cnt <= rst_cnt + 1'b1;
                    end
                end
                LRPM_SEQ_RUN: begin
                    if (start_reset) begin
                        seq <= LRPM_SEQ_RESET;
                        rst_cnt <= '0;
                    end
                end
                default: begin
                    seq <= LRPM_SEQ_RESET;
                    rst_cnt <= '0;
                end
            endcase
        end
    end

    // Internal oscillator ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_cnt <= '0;
            osc_tick <= 1'b0;
        end else begin
            osc_tick <= osc_cnt == OCW'(OSC_DIV - 1);
            osc_cnt <= (osc_cnt == OCW'(OSC_DIV - 1)) ? '0 : osc_cnt + 1'b1;
        end
    end

    // Control registers; reset restores, sleep keeps
    wire in_reset = rip || start_reset;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            driver_enable_bit <= 1'b0;
            row_mirror <= 1'b0;
            column_mirror <= 1'b0;
            start_line_offset <= SL_RESET;
            last_scanned_row <= LAST_ROW_RESET;
        end else if (in_reset) begin
            driver_enable_bit <= 1'b0;
            row_mirror <= 1'b0;
            column_mirror <= 1'b0;
            start_line_offset <= SL_RESET;
            last_scanned_row <= LAST_ROW_RESET;
        end else begin
            if (disp_cmd) begin
                driver_enable_bit <= cmd[0];
            end
            if (map_cmd) begin
                row_mirror <= cmd[MAP_ROW_MIRROR_BIT];
                column_mirror <= cmd[MAP_COL_MIRROR_BIT];
            end
            if (cmd_ok && hit_cfg && pstrb[0]) begin
                start_line_offset <= pwdata[CFG_SL_LSB +: 7];
            end
            if (cmd_ok && hit_cfg && pstrb[1]) begin
                last_scanned_row <= pwdata[CFG_LAST_ROW_LSB +: 7];
            end
        end
    end

    // Display data byte survives reset and sleep
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            display_byte <= 8'h00;
        end else if (cmd_ok && hit_data) begin
            display_byte <= pwdata[7:0];
        end
    end

    // Operating mode; sleep and normal applied on oscillator ticks, reset immediately
    wire drv_change = disp_cmd && cmd[0] != driver_enable_bit;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= LRPM_MODE_RESET;
            mode_pending <= 1'b0;
        end else if (in_reset) begin
            mode <= LRPM_MODE_RESET;
            mode_pending <= 1'b0;
        end else if (drv_change) begin
            mode_pending <= 1'b1;
        end else if (mode_pending && osc_tick) begin
            mode <= driver_enable_bit ? LRPM_MODE_NORMAL : LRPM_MODE_SLEEP;
            mode_pending <= 1'b0;
        end
    end

    wire normal = mode == LRPM_MODE_NORMAL;

    // Analogue controls and driver gating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_en <= 1'b0;
            pump_en <= 1'b0;
            row_drv_en <= 1'b0;
            col_drv_en <= 1'b0;
            drain_vlcd_en <= 1'b1;
            drain_bias_en <= 1'b1;
        end else begin
            osc_en <= normal;
            pump_en <= normal && !ext_vlcd;
            row_drv_en <= normal && volts_ready;
            col_drv_en <= normal && volts_ready;
            drain_vlcd_en <= !normal && !ext_vlcd;
            drain_bias_en <= !normal;
        end
    end

    // Line address generation
    wire [6:0] first_line = row_mirror ? start_line_offset + last_scanned_row : start_line_offset;
    wire frame_end = row_cnt == last_scanned_row;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            row_cnt <= 7'h00;
            scan_line <= 7'h00;
            frame_start <= 1'b0;
        end else if (!normal) begin
            row_cnt <= 7'h00;
            scan_line <= first_line;
            frame_start <= 1'b0;
        end else if (osc_tick) begin
            frame_start <= frame_end;
            if (frame_end) begin
                row_cnt <= 7'h00;
                scan_line <= first_line;
            end else begin
                row_cnt <= row_cnt + 7'h01;
                scan_line <= row_mirror ? scan_line - 7'h01 : scan_line + 7'h01;
            end
        end else begin
            frame_start <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_pixel <= 2'b00;
        end else begin
            scan_pixel <= pixel_of(display_byte, scan_line[1:0]);
        end
    end

    // Status flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_in_progress_flag <= 1'b1;
            busy_flag <= 1'b1;
            operating_mode_field <= LRPM_MODE_RESET;
        end else begin
            reset_in_progress_flag <= rip;
            busy_flag <= rip || mode_pending;
            operating_mode_field <= mode;
        end
    end

    // Read data
    wire [7:0] status_byte = {2'b00, busy_flag, reset_in_progress_flag, row_drv_en,
                              driver_enable_bit, operating_mode_field};
    wire [31:0] cfg_word = {17'h00000, last_scanned_row, 1'b0, start_line_offset};
    wire [31:0] scan_word = {23'h000000, row_mirror, column_mirror, scan_line};
    wire [31:0] rd_sel = hit_cmd ? {24'h000000, status_byte} :
                         rip ? 32'h00000000 :
                         hit_data ? {24'h000000, display_byte} :
                         hit_cfg ? cfg_word :
                         hit_scan ? scan_word : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
            prdata <= (setup && !pwrite) ? rd_sel : 32'h00000000;
        end
    end

endmodule // lrpm_ctrl

// ===== sim/lrpm_checker.sv
// Concurrent checks on the reset and power-mode sequencer ports.
// Assumes it is bound to lrpm_ctrl; one clock, pclk.
`timescale 1ns/100ps
module lrpm_checker
    import lrpm_pkg::*;
#(
    parameter int OSC_DIV = OSC_DIV_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic vlcd_ready,
    input wire logic vbias_ready,
    input wire logic vlcd_external,
    input wire logic reset_in_progress_flag,
    input wire logic busy_flag,
    input wire logic [1:0] operating_mode_field,
    input wire logic row_drv_en,
    input wire logic col_drv_en,
    input wire logic drain_vlcd_en,
    input wire logic drain_bias_en
);
    localparam int MODE_LAT = OSC_DIV + 3;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_cmd(logic [7:0] c);
        psel && penable && pready && pwrite && paddr == OFS_CMD && pwdata[7:0] == c;
    endsequence
    property p_flags;
        reset_in_progress_flag && $past(reset_in_progress_flag) |-> busy_flag && operating_mode_field == LRPM_MODE_RESET;
    endproperty
    a_flags: assert property (p_flags) else $error("flags or mode wrong in reset");
    property p_sleep;
        s_cmd(CMD_DISP_VAL) ##0 (!reset_in_progress_flag && operating_mode_field == LRPM_MODE_NORMAL)
            |-> ##[1:MODE_LAT] operating_mode_field == LRPM_MODE_SLEEP;
    endproperty
    a_sleep: assert property (p_sleep) else $error("display off did not reach sleep");
    property p_wake;
        s_cmd(CMD_DISP_VAL | 8'h01) ##0 (!reset_in_progress_flag && operating_mode_field != LRPM_MODE_NORMAL)
            |-> ##[1:MODE_LAT] operating_mode_field == LRPM_MODE_NORMAL;
    endproperty
    a_wake: assert property (p_wake) else $error("display on did not reach normal");
    property p_reset_cmd;
        s_cmd(CMD_SYS_RESET) |-> ##[1:4] reset_in_progress_flag;
    endproperty
    a_reset_cmd: assert property (p_reset_cmd) else $error("reset command not started");
    property p_ignore;
        s_cmd(CMD_DISP_VAL | 8'h01) ##0 reset_in_progress_flag |=> (operating_mode_field == LRPM_MODE_RESET)[*8];
    endproperty
    a_ignore: assert property (p_ignore) else $error("command acted on during reset");
    property p_drv_mode;
        row_drv_en |-> col_drv_en && operating_mode_field == LRPM_MODE_NORMAL;
    endproperty
    a_drv_mode: assert property (p_drv_mode) else $error("drivers on outside normal");
    property p_drain;
        $stable(operating_mode_field) |-> drain_bias_en == (operating_mode_field != LRPM_MODE_NORMAL);
    endproperty
    a_drain: assert property (p_drain) else $error("drain path wrong for mode");
    property p_ext;
        vlcd_external[*6] |-> !drain_vlcd_en;
    endproperty
    a_ext: assert property (p_ext) else $error("external drive voltage drained");
    property p_drv_ready;
        $rose(row_drv_en) |-> $past(vlcd_ready, 3) && $past(vbias_ready, 3);
    endproperty
    a_drv_ready: assert property (p_drv_ready) else $error("drivers on before voltages ready");
    property p_ready;
        psel && !penable |=> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("host access not answered");
endmodule // lrpm_checker

// ===== sim/lrpm_host.sv
// Host processor model: issues commands and reads over APB.
// Assumes the slave answers with pready in the access phase.
`timescale 1ns/100ps
module lrpm_host (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'h0;
    end
    // One transfer; calls issued one after another leave one idle pclk cycle between transfers
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hF;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
endmodule // lrpm_host

// ===== sim/tb_top.sv
// Self-checking bench for the reset and power-mode sequencer.
// Assumes short sim counts; host model drives APB.
`timescale 1ns/100ps
module tb_top;
    import lrpm_pkg::*;
    localparam int OSC = 4;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic reset_pin_n, vlcd_ready, vbias_ready, vlcd_external, frame_start;
    logic reset_in_progress_flag, busy_flag, osc_en, pump_en, row_drv_en, col_drv_en, drain_vlcd_en, drain_bias_en;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [1:0] operating_mode_field, scan_pixel;
    logic [6:0] scan_line;
    int fails = 0;
    int cmp_count = 0;
    int cycles = 0;
    typedef struct {logic [7:0] cmd; logic [7:0] st; logic drv; logic drain;} lrpm_row_t;
    lrpm_row_t rows [4] = '{'{8'hAF, 8'h0F, 1'b1, 1'b0}, '{8'hAE, 8'h02, 1'b0, 1'b1},
                            '{8'hAF, 8'h0F, 1'b1, 1'b0}, '{8'hAE, 8'h02, 1'b0, 1'b1}};
    lrpm_ctrl #(.POR_CYCLES(20), .RESET_SEQ_CYCLES(40), .OSC_DIV(OSC)) dut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .reset_pin_n, .vlcd_ready, .vbias_ready,
        .vlcd_external, .reset_in_progress_flag, .busy_flag, .operating_mode_field, .osc_en, .pump_en,
        .row_drv_en, .col_drv_en, .drain_vlcd_en, .drain_bias_en, .frame_start, .scan_line, .scan_pixel);
    lrpm_host u_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr);
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            report_and_stop();
        end
    end
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d, rd, err);
    endtask
    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] exp);
        u_host.xfer(1'b0, a, 32'h0, rd, err);
        chk(n, rd, exp);
    endtask
    // Ten microseconds at 40 MHz before relying on the new state
    task automatic settle;
        repeat (400) @(posedge pclk);
    endtask
    task automatic wait_rip;
        for (int i = 0; i < 300 && reset_in_progress_flag !== 1'b0; i++) @(posedge pclk);
    endtask
    initial begin
        presetn = 1'b0;
        reset_pin_n = 1'b1;
        vlcd_ready = 1'b1;
        vbias_ready = 1'b1;
        vlcd_external = 1'b0;
        repeat (3) @(posedge pclk);
        chk("reset outputs", 32'({busy_flag, reset_in_progress_flag, operating_mode_field, drain_bias_en}), 32'h19);
        presetn <= 1'b1;
        rdc("status in wait", OFS_CMD, 32'h30);
        wr(OFS_CFG, 32'h0000_1234);
        wait_rip();
        rdc("cfg default", OFS_CFG, 32'h0000_7F00);
        $display("test power-up done");
        foreach (rows[i]) begin
            wr(OFS_CMD, {24'h0, rows[i].cmd});
            settle();
            rdc("status", OFS_CMD, {24'h0, rows[i].st});
            chk("drivers", 32'({row_drv_en, col_drv_en}), {30'h0, {2{rows[i].drv}}});
            chk("drain osc", 32'({drain_bias_en, osc_en}), {30'h0, rows[i].drain, ~rows[i].drain});
        end
        $display("test mode table done");
        vlcd_ready <= 1'b0;
        wr(OFS_CMD, 32'hAF);
        settle();
        chk("drivers not ready", 32'(row_drv_en), 32'h0);
        vlcd_ready <= 1'b1;
        repeat (8) @(posedge pclk);
        chk("drivers ready", 32'(row_drv_en), 32'h1);
        wr(OFS_CFG, 32'h0000_3A05);
        wr(OFS_DATA, 32'h0000_00A5);
        wr(OFS_CMD, 32'hAE);
        settle();
        rdc("cfg kept", OFS_CFG, 32'h0000_3A05);
        rdc("data kept", OFS_DATA, 32'h0000_00A5);
        $display("test sleep retention done");
        wr(OFS_CMD, 32'hE2);
        wr(OFS_CMD, 32'hAF);
        chk("reset flag", 32'(reset_in_progress_flag), 32'h1);
        wait_rip();
        settle();
        rdc("status after reset", OFS_CMD, 32'h0);
        rdc("cfg after reset", OFS_CFG, 32'h0000_7F00);
        $display("test reset command done");
        wr(OFS_CMD, 32'hAF);
        settle();
        reset_pin_n <= 1'b0;
        repeat (6) @(posedge pclk);
        chk("pin reset", 32'({reset_in_progress_flag, operating_mode_field, row_drv_en}), 32'h8);
        vlcd_external <= 1'b1;
        repeat (8) @(posedge pclk);
        chk("external drain", 32'({drain_vlcd_en, drain_bias_en, pump_en}), 32'h2);
        vlcd_external <= 1'b0;
        reset_pin_n <= 1'b1;
        wait_rip();
        u_host.xfer(1'b0, 8'h10, 32'h0, rd, err);
        chk("unmapped error", 32'(err), 32'h1);
        $display("test pin reset and unmapped done");
        wr(OFS_CFG, 32'h0000_0310);
        wr(OFS_CMD, 32'hC4);
        rdc("scan idle", OFS_SCAN, 32'h0000_0113);
        wr(OFS_CMD, 32'hAF);
        for (int i = 0; i < 200 && frame_start !== 1'b1; i++) @(posedge pclk);
        chk("frame first line", 32'(scan_line), 32'h13);
        @(posedge pclk);
        chk("frame pixel", 32'(scan_pixel), 32'h2);
        $display("test scan done");
        report_and_stop();
    end
endmodule // tb_top
bind lrpm_ctrl lrpm_checker #(.OSC_DIV(OSC_DIV)) u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .vlcd_ready, .vbias_ready, .vlcd_external, .reset_in_progress_flag, .busy_flag,
    .operating_mode_field, .row_drv_en, .col_drv_en, .drain_vlcd_en, .drain_bias_en);
